//--- shared/ppfs_defs.svh
// Offsets, field positions and reset values of the pin function selector
`ifndef PPFS_DEFS_SVH
`define PPFS_DEFS_SVH

`define PPFS_ADDR_SEL1        32'hE002_C004
`define PPFS_ADDR_SEL2        32'hE002_C014
`define PPFS_ADDR_GPIO_BASE   32'hE002_C100
`define PPFS_GPIO_STRIDE      32'h0000_0020
`define PPFS_GPIO_LEVEL       32'h0000_0000
`define PPFS_GPIO_SET         32'h0000_0004
`define PPFS_GPIO_DIR         32'h0000_0008
`define PPFS_GPIO_CLR         32'h0000_000C

`define PPFS_SEL1_WMASK       32'h3FFC_FFFF
`define PPFS_SEL2_WMASK       32'h0000_000C
`define PPFS_SEL_RESET        32'h0000_0000
`define PPFS_DIR_RESET        32'h0000_0000
`define PPFS_OUT_RESET        32'h0000_0000

`define PPFS_P25_LSB          18
`define PPFS_P26_LSB          20
`define PPFS_P30_LSB          28
`define PPFS_DEBUG_BIT        2
`define PPFS_TRACE_BIT        3

`endif

//--- shared/ppfs_pkg.sv
// Types shared by the pin function selector modules
package ppfs_pkg;

  typedef enum logic [1:0] {
    PPFS_FUNC_GPIO = 2'b00,
    PPFS_FUNC_ALT1 = 2'b01,
    PPFS_FUNC_ALT2 = 2'b10,
    PPFS_FUNC_ALT3 = 2'b11
  } ppfs_func_e;

  typedef struct packed {
    logic oe;
    logic out;
  } ppfs_pad_s;

  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } ppfs_cmd_s;

endpackage

//--- hdl/ppfs_pin_cell.sv
// One pad: registered choice between GPIO drive and alternate drive
`timescale 1ns/100ps
module ppfs_pin_cell
  import ppfs_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  // Selection
  input  wire logic            i_gpio_sel,
  input  wire logic            i_gpio_out,
  input  wire logic            i_gpio_dir,
  input  wire ppfs_pkg::ppfs_pad_s i_alt,
  // Pad drive
  output ppfs_pkg::ppfs_pad_s  o_pad
);
  import ppfs_pkg::*;

  ppfs_pad_s pad_q;
  ppfs_pad_s pad_d;

  // Direction bit counts only in GPIO mode
  assign pad_d = i_gpio_sel ? ppfs_pad_s'{oe: i_gpio_dir, out: i_gpio_out}
                            : i_alt;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pad_q <= '{oe: 1'b0, out: 1'b0};
    else
      pad_q <= pad_d;
  end

  assign o_pad = pad_q;

endmodule

//--- hdl/ppfs_bus_slave.sv
// Avalon-MM slave front end with one wait state
`timescale 1ns/100ps
module ppfs_bus_slave
  import ppfs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [31:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Register file side
  input  wire logic [31:0] i_rd_data,
  output ppfs_pkg::ppfs_cmd_s o_cmd
);
  import ppfs_pkg::*;

  logic        ack_q;
  logic [31:0] rdata_q;
  wire         req;
  wire         first;

  assign req   = i_avs_read | i_avs_write;
  assign first = req & ~ack_q;

  // Request is accepted at the second edge
  assign o_avs_waitrequest = first;
  assign o_cmd = '{wr: i_avs_write & ack_q, addr: i_avs_address,
                   wdata: i_avs_writedata, be: i_avs_byteenable};

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= first;
      if (first && i_avs_read)
        rdata_q <= i_rd_data;
    end
  end

  assign o_avs_readdata = rdata_q;

endmodule

//--- hdl/ppfs_top.sv
// Pin function selector with GPIO register bank for ports 0 and 1
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "ppfs_defs.svh"
module ppfs_top
  import ppfs_pkg::*;
#(
  parameter bit HAS_DAC = 1'b1
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [31:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Port 0 pads
  input  wire logic [31:0] i_p0_level,
  output ppfs_pkg::ppfs_pad_s [31:0] o_p0_pad,
  // Port 1 pads
  input  wire logic [31:0] i_p1_level,
  output ppfs_pkg::ppfs_pad_s [31:0] o_p1_pad,
  // Port 0 pins 16 to 23 alternate drive and chosen codes
  input  wire ppfs_pkg::ppfs_pad_s [7:0] i_p0_low_alt,
  output logic      [15:0] o_p0_low_func,
  // Timer 0, interrupt and analog connections
  input  wire logic [3:1]  i_timer0_match,
  output logic      [3:0]  o_timer0_capture,
  output logic             o_ext_int3,
  output logic      [5:0]  o_adc0_connect,
  output logic             o_dac_connect,
  // Debug and trace ports
  input  wire ppfs_pkg::ppfs_pad_s [5:0] i_debug_drive,
  output logic      [5:0]  o_debug_level,
  output logic             o_debug_mode,
  input  wire logic [9:0]  i_trace_data,
  output logic             o_trace_mode
);
  import ppfs_pkg::*;

  // Byte-lane merge of write data
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // Two-bit selector field of the first register
  function automatic ppfs_func_e field_of(
    input logic [31:0] reg_v,
    input int          lsb
  );
    return ppfs_func_e'(reg_v[lsb +: 2]);
  endfunction

  // Bus front end
  ppfs_cmd_s   cmd;
  logic [31:0] rd_data;

  ppfs_bus_slave u_bus
  (
    .i_clk             (i_clk),
    .i_reset_n         (i_reset_n),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_rd_data         (rd_data),
    .o_cmd             (cmd)
  );

  // Selector registers
  logic [31:0] sel1_q;
  logic [31:0] sel1_d;
  logic [31:0] sel2_q;
  logic [31:0] sel2_d;
  wire         hit_sel1;
  wire         hit_sel2;

  assign hit_sel1 = (cmd.addr == `PPFS_ADDR_SEL1);
  assign hit_sel2 = (cmd.addr == `PPFS_ADDR_SEL2);

  // Reserved bits are masked off on write
  assign sel1_d = lane_merge(sel1_q, cmd.wdata, cmd.be)
                  & `PPFS_SEL1_WMASK;
  assign sel2_d = lane_merge(sel2_q, cmd.wdata, cmd.be)
                  & `PPFS_SEL2_WMASK;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel1_q <= `PPFS_SEL_RESET;
      sel2_q <= `PPFS_SEL_RESET;
    end
    else
    begin
      if (cmd.wr && hit_sel1)
        sel1_q <= sel1_d;
      if (cmd.wr && hit_sel2)
        sel2_q <= sel2_d;
    end
  end

  // GPIO registers, one bank per port
  logic [1:0][31:0] gpio_dir;
  logic [1:0][31:0] gpio_out;
  logic [1:0][31:0] level;
  logic [1:0][31:0] rd_port;

  assign level[0] = i_p0_level;
  assign level[1] = i_p1_level;

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_bank
      wire  [31:0] base;
      wire         hit_level;
      wire         hit_set;
      wire         hit_dir;
      wire         hit_clr;
      wire  [31:0] wmask;
      logic [31:0] dir_q;
      logic [31:0] out_q;

      assign gpio_dir[p] = dir_q;
      assign gpio_out[p] = out_q;

      assign base      = `PPFS_ADDR_GPIO_BASE
                         + (`PPFS_GPIO_STRIDE * 32'(p));
      assign hit_level = (cmd.addr == base + `PPFS_GPIO_LEVEL);
      assign hit_set   = (cmd.addr == base + `PPFS_GPIO_SET);
      assign hit_dir   = (cmd.addr == base + `PPFS_GPIO_DIR);
      assign hit_clr   = (cmd.addr == base + `PPFS_GPIO_CLR);
      assign wmask     = lane_merge(32'h0000_0000, cmd.wdata, cmd.be);

      always_ff @(posedge i_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          dir_q <= `PPFS_DIR_RESET;
          out_q <= `PPFS_OUT_RESET;
        end
        else
        begin
          if (cmd.wr && hit_dir)
            dir_q <= lane_merge(dir_q, cmd.wdata, cmd.be);
          if (cmd.wr && hit_set)
            out_q <= out_q | wmask;
          else if (cmd.wr && hit_clr)
            out_q <= out_q & ~wmask;
        end
      end

      // Set address reads the output register, level address the pins
      assign rd_port[p] = ({32{hit_level}} & level[p])
                        | ({32{hit_set}}   & out_q)
                        | ({32{hit_dir}}   & dir_q);
    end
  endgenerate

  // Read data selection; unmapped addresses read zero
  assign rd_data = ({32{hit_sel1}} & sel1_q)
                 | ({32{hit_sel2}} & sel2_q)
                 | rd_port[0]
                 | rd_port[1];

  // Pin routing tables
  logic      [1:0][31:0] gpio_sel;
  ppfs_pad_s [1:0][31:0] alt;

  ppfs_func_e f25;
  ppfs_func_e f26;
  ppfs_func_e f30;
  wire        debug_mode;
  wire        trace_mode;

  assign f25 = field_of(sel1_q, `PPFS_P25_LSB);
  assign f26 = field_of(sel1_q, `PPFS_P26_LSB);
  assign f30 = field_of(sel1_q, `PPFS_P30_LSB);
  assign debug_mode = sel2_q[`PPFS_DEBUG_BIT];
  assign trace_mode = sel2_q[`PPFS_TRACE_BIT];

  // Port 0 pins 0 to 15 stay GPIO here
  assign gpio_sel[0][15:0] = 16'hFFFF;
  assign alt[0][15:0]      = '0;

  // Port 0 pins 16 to 23 take their drive from outside
  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_low
      assign gpio_sel[0][16+k] = (field_of(sel1_q, 2*k)
                                  == PPFS_FUNC_GPIO);
      assign alt[0][16+k]      = i_p0_low_alt[k];
    end
  endgenerate

  // Pin 24 and pin 31 have only GPIO usable
  assign gpio_sel[0][24] = 1'b1;
  assign gpio_sel[0][31] = 1'b1;
  assign alt[0][24]      = '0;
  assign alt[0][31]      = '0;

  // Pin 25: analog input, DAC output or reserved, never driven digitally
  assign gpio_sel[0][25] = (f25 == PPFS_FUNC_GPIO);
  assign alt[0][25]      = '{oe: 1'b0, out: 1'b0};

  // Pin 26: analog input 5
  assign gpio_sel[0][26] = (f26 == PPFS_FUNC_GPIO);
  assign alt[0][26]      = '{oe: 1'b0, out: 1'b0};

  // Pins 27 to 29: analog, capture input or match output
  ppfs_func_e [3:1] fm;
  generate
    for (k = 1; k < 4; k++)
    begin : g_match
      assign fm[k] = field_of(sel1_q, 20 + 2*k);
      assign gpio_sel[0][26+k] = (fm[k] == PPFS_FUNC_GPIO);
      // Only a match output drives the pad
      assign alt[0][26+k] = '{oe:  fm[k] == PPFS_FUNC_ALT3,
                              out: i_timer0_match[k]};
    end
  endgenerate

  // Pin 30: analog, interrupt 3 or capture 0, all inputs
  assign gpio_sel[0][30] = (f30 == PPFS_FUNC_GPIO);
  assign alt[0][30]      = '{oe: 1'b0, out: 1'b0};

  // Port 1 groups for debug and trace
  genvar j;
  generate
    for (j = 0; j < 32; j++)
    begin : g_p1
      if (j >= 26)
      begin : g_dbg
        assign gpio_sel[1][j] = ~debug_mode;
        assign alt[1][j]      = i_debug_drive[j-26];
      end
      else if (j >= 16)
      begin : g_trc
        assign gpio_sel[1][j] = ~trace_mode;
        assign alt[1][j]      = '{oe: 1'b1, out: i_trace_data[j-16]};
      end
      else
      begin : g_plain
        assign gpio_sel[1][j] = 1'b1;
        assign alt[1][j]      = '0;
      end
    end
  endgenerate

  // Pad cells
  ppfs_pad_s [1:0][31:0] pad;
  genvar q;
  genvar n;
  generate
    for (q = 0; q < 2; q++)
    begin : g_port
      for (n = 0; n < 32; n++)
      begin : g_pin
        ppfs_pin_cell u_cell
        (
          .i_clk      (i_clk),
          .i_reset_n  (i_reset_n),
          .i_gpio_sel (gpio_sel[q][n]),
          .i_gpio_out (gpio_out[q][n]),
          .i_gpio_dir (gpio_dir[q][n]),
          .i_alt      (alt[q][n]),
          .o_pad      (pad[q][n])
        );
      end
    end
  endgenerate

  assign o_p0_pad = pad[0];
  assign o_p1_pad = pad[1];

  // Peripheral-side outputs
  logic [3:0] cap_d;
  logic [5:0] adc_d;
  logic [5:0] dbg_d;

  assign cap_d[0] = (f30 == PPFS_FUNC_ALT3) & i_p0_level[30];
  generate
    for (k = 1; k < 4; k++)
    begin : g_cap
      assign cap_d[k] = (fm[k] == PPFS_FUNC_ALT2)
                        & i_p0_level[26+k];
      assign adc_d[k-1] = (fm[k] == PPFS_FUNC_ALT1);
    end
  endgenerate
  assign adc_d[3] = (f30 == PPFS_FUNC_ALT1);
  assign adc_d[4] = (f25 == PPFS_FUNC_ALT1);
  assign adc_d[5] = (f26 == PPFS_FUNC_ALT1);
  assign dbg_d    = debug_mode ? i_p1_level[31:26] : 6'h00;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_timer0_capture <= 4'h0;
      o_ext_int3       <= 1'b0;
      o_adc0_connect   <= 6'h00;
      o_dac_connect    <= 1'b0;
      o_debug_level    <= 6'h00;
      o_debug_mode     <= 1'b0;
      o_trace_mode     <= 1'b0;
      o_p0_low_func    <= 16'h0000;
    end
    else
    begin
      o_timer0_capture <= cap_d;
      o_ext_int3       <= (f30 == PPFS_FUNC_ALT2) & i_p0_level[30];
      o_adc0_connect   <= adc_d;
      o_dac_connect    <= (f25 == PPFS_FUNC_ALT2) & HAS_DAC;
      o_debug_level    <= dbg_d;
      o_debug_mode     <= debug_mode;
      o_trace_mode     <= trace_mode;
      o_p0_low_func    <= sel1_q[15:0];
    end
  end

endmodule

//--- verification/ppfs_top_assertions.sv
// Checker of bus wait states and pad hand-over
`timescale 1ns/100ps
module ppfs_top_chk
  import ppfs_pkg::*;
(
  // Clock, reset and bus
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire logic                      i_avs_read,
  input wire logic                      i_avs_write,
  input wire logic                      o_avs_waitrequest,
  // Pads and peripheral side
  input wire ppfs_pkg::ppfs_pad_s [31:0] o_p0_pad,
  input wire ppfs_pkg::ppfs_pad_s [31:0] o_p1_pad,
  input wire ppfs_pkg::ppfs_pad_s [5:0]  i_debug_drive,
  input wire logic [9:0]                i_trace_data,
  input wire logic                      o_debug_mode,
  input wire logic                      o_trace_mode,
  input wire logic [5:0]                o_debug_level,
  input wire logic                      o_dac_connect,
  input wire logic [5:0]                o_adc0_connect
);
  import ppfs_pkg::*;

  logic [31:0] p0_oe;
  logic [31:0] p1_oe;
  logic [31:0] p1_out;
  logic        req;
  assign req = i_avs_read | i_avs_write;
  always_comb
  begin
    for (int k = 0; k < 32; k++)
    begin
      p0_oe[k]  = o_p0_pad[k].oe;
      p1_oe[k]  = o_p1_pad[k].oe;
      p1_out[k] = o_p1_pad[k].out;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_pend;
    req && o_avs_waitrequest;
  endsequence
  sequence s_ack;
    req && !o_avs_waitrequest;
  endsequence
  sequence s_debug_held;
    o_debug_mode && $past(o_debug_mode);
  endsequence
  sequence s_debug_off;
    !o_debug_mode && !$past(o_debug_mode);
  endsequence
  sequence s_trace_held;
    o_trace_mode && $past(o_trace_mode);
  endsequence
  AST_FIRST_WAIT: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("new request without wait state");
  AST_ONE_WAIT: assert property (s_pend |=> s_ack)
    else $error("more than one wait state");
  AST_IDLE_NO_WAIT: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait state with no request");
  AST_RESET_INPUTS: assert property ($rose(i_reset_n) |->
    (p0_oe | p1_oe) == 32'h0000_0000)
    else $error("pad driven after reset");
  AST_DEBUG_DRIVE: assert property (s_debug_held |->
    o_p1_pad[31:26] == $past(i_debug_drive))
    else $error("debug group not driven by debug port");
  AST_DEBUG_IDLE: assert property (s_debug_off |->
    o_debug_level == 6'h00)
    else $error("debug level seen outside debug mode");
  AST_TRACE_DRIVE: assert property (s_trace_held |->
    p1_oe[25:16] == 10'h3FF && p1_out[25:16] == $past(i_trace_data))
    else $error("trace group not driven by trace data");
  AST_DAC_UNDRIVEN: assert property (o_dac_connect |-> !p0_oe[25])
    else $error("analog output pin driven digitally");
  AST_ADC_UNDRIVEN: assert property (o_adc0_connect != 6'h00 |->
    ({o_adc0_connect[5:4], o_adc0_connect[3:0]}
     & {p0_oe[26:25], p0_oe[30:27]}) == 6'h00)
    else $error("analog input pin driven digitally");
endmodule

bind ppfs_top ppfs_top_chk chk_u (.i_clk, .i_reset_n, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .o_p0_pad, .o_p1_pad, .i_debug_drive,
  .i_trace_data, .o_debug_mode, .o_trace_mode, .o_debug_level,
  .o_dac_connect, .o_adc0_connect);

//--- verification/ppfs_periph_model.sv
// Peripheral side: timer match, debug, trace and low-pin drive
`timescale 1ns/100ps
module ppfs_periph_model
  import ppfs_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // Drive toward the selector
  output logic [3:1]                o_match,
  output ppfs_pkg::ppfs_pad_s [5:0] o_debug_drive,
  output logic [9:0]                o_trace_data,
  output ppfs_pkg::ppfs_pad_s [7:0] o_low_alt
);
  import ppfs_pkg::*;

  logic [15:0] cnt_q;
  // Pattern moves every cycle so stale drive shows
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h1357;
  end
  assign o_match       = cnt_q[3:1];
  assign o_debug_drive = cnt_q[11:0];
  assign o_trace_data  = cnt_q[15:6];
  assign o_low_alt     = ~cnt_q;
endmodule

//--- verification/ppfs_top_test.sv
// Self-checking bench of the pin function selector
`timescale 1ns/100ps
`include "ppfs_defs.svh"
module ppfs_top_test;
  import ppfs_pkg::*;
  logic             i_clk;
  logic             i_reset_n;
  logic [31:0]      i_avs_address;
  logic             i_avs_read;
  logic             i_avs_write;
  logic [31:0]      i_avs_writedata;
  logic [3:0]       i_avs_byteenable;
  logic [31:0]      o_avs_readdata;
  logic             o_avs_waitrequest;
  logic [31:0]      i_p0_level;
  logic [31:0]      i_p1_level;
  ppfs_pad_s [31:0] o_p0_pad;
  ppfs_pad_s [31:0] o_p1_pad;
  ppfs_pad_s [7:0]  low_alt;
  ppfs_pad_s [5:0]  dbg_drv;
  logic [3:1]       match;
  logic [9:0]       trace;
  logic [3:0]       cap;
  logic [5:0]       adc;
  logic [5:0]       dbg_lvl;
  logic [15:0]      low_func;
  logic             ext;
  logic             dac;
  logic             dbg_mode;
  logic             trc_mode;
  logic [31:0]      rd;
  int               errors;
  int               cmp_count;
  localparam logic [31:0] P0 = `PPFS_ADDR_GPIO_BASE;
  localparam logic [31:0] P1 = P0 + `PPFS_GPIO_STRIDE;

  ppfs_top dut_u (.i_clk, .i_reset_n, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .i_p0_level, .o_p0_pad, .i_p1_level, .o_p1_pad,
    .i_p0_low_alt(low_alt), .o_p0_low_func(low_func), .i_timer0_match(match),
    .o_timer0_capture(cap), .o_ext_int3(ext), .o_adc0_connect(adc),
    .o_dac_connect(dac), .i_debug_drive(dbg_drv), .o_debug_level(dbg_lvl),
    .o_debug_mode(dbg_mode), .i_trace_data(trace), .o_trace_mode(trc_mode));
  ppfs_periph_model per_u (.i_clk, .i_reset_n, .o_match(match),
    .o_debug_drive(dbg_drv), .o_trace_data(trace), .o_low_alt(low_alt));

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] pv(input ppfs_pad_s [31:0] p,
                                     input logic o);
    for (int k = 0; k < 32; k++)
      pv[k] = o ? p[k].oe : p[k].out;
  endfunction
  task automatic bus(input logic r, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_avs_read      <= r;
    i_avs_write     <= !r;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
      if (n > 20)
      begin
        errors++;
        summarize();
      end
    end
    while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask

  task automatic t_reset();
    @(negedge i_clk);
    chk(pv(o_p0_pad, 1'b1) | pv(o_p1_pad, 1'b1), 32'h0000_0000);
    rdc(`PPFS_ADDR_SEL1, 32'h0000_0000);
    rdc(`PPFS_ADDR_SEL2, 32'h0000_0000);
    rdc(P1 + `PPFS_GPIO_DIR, 32'h0000_0000);
  endtask
  task automatic t_mask();
    wr(`PPFS_ADDR_SEL1, 32'hFFC3_1555);
    rdc(`PPFS_ADDR_SEL1, 32'h3FC0_1555);
    chk({16'h0000, low_func}, 32'h0000_1555);
    wr(`PPFS_ADDR_SEL2, 32'hFFFF_FFFF);
    rdc(`PPFS_ADDR_SEL2, 32'h0000_000C);
    wr(32'hE002_C008, 32'hFFFF_FFFF);
    rdc(32'hE002_C008, 32'h0000_0000);
    wr(`PPFS_ADDR_SEL1, 32'h0000_0000);
    wr(`PPFS_ADDR_SEL2, 32'h0000_0000);
  endtask
  task automatic t_gpio();
    wr(P0 + `PPFS_GPIO_DIR, 32'h0000_F00F);
    wr(P0 + `PPFS_GPIO_SET, 32'h0000_A005);
    wr(P0 + `PPFS_GPIO_CLR, 32'h0000_0001);
    rdc(P0 + `PPFS_GPIO_SET, 32'h0000_A004);
    rdc(P0 + `PPFS_GPIO_CLR, 32'h0000_0000);
    rdc(P0 + `PPFS_GPIO_DIR, 32'h0000_F00F);
    rdc(P0 + `PPFS_GPIO_LEVEL, i_p0_level);
    settle();
    chk(pv(o_p0_pad, 1'b1), 32'h0000_F00F);
    chk(pv(o_p0_pad, 1'b0) & 32'h0000_F00F, 32'h0000_A004);
  endtask
  task automatic t_alt();
    logic [31:0] e;
    logic [31:0] oe;
    logic [31:0] got;
    wr(P0 + `PPFS_GPIO_DIR, 32'h7A00_0000);
    for (int p = 0; p < 4; p++)
      for (int c = 1; c < 4; c++)
      begin
        wr(`PPFS_ADDR_SEL1, 32'(c) << (22 + 2 * p));
        settle();
        oe = pv(o_p0_pad, 1'b1);
        if (c == 1)
          e = 32'h1 << (9 + p);
        else if (c == 2)
          e = (p < 3) ? 32'h1 << (6 + p) : 32'h0000_0010;
        else
          e = (p < 3) ? 32'h1 << p : 32'h0000_0020;
        e = e | (32'h0000_000F & ~(32'h1 << p));
        got = {19'h0, adc[3:0], cap, ext, oe[30:27]};
        chk(got, e);
      end
    for (int c = 0; c < 3; c++)
    begin
      wr(`PPFS_ADDR_SEL1, 32'(c) << `PPFS_P25_LSB);
      settle();
      oe = pv(o_p0_pad, 1'b1);
      e = (c == 0) ? 32'h1 : ((c == 1) ? 32'h4 : 32'h2);
      chk({29'h0, adc[4], dac, oe[25]}, e);
    end
    wr(`PPFS_ADDR_SEL1, 32'h0000_0000);
  endtask
  task automatic t_port1();
    wr(`PPFS_ADDR_SEL2, 32'h0000_0004);
    settle();
    chk({25'h0, dbg_mode, dbg_lvl}, 32'h0000_0069);
    wr(`PPFS_ADDR_SEL2, 32'h0000_0008);
    settle();
    chk({dbg_mode, trc_mode}, 32'h0000_0001);
    chk(pv(o_p1_pad, 1'b1), 32'h03FF_0000);
    wr(P1 + `PPFS_GPIO_DIR, 32'hFFFF_FFFF);
    wr(`PPFS_ADDR_SEL2, 32'h0000_0000);
    wr(P1 + `PPFS_GPIO_SET, 32'hF000_0001);
    settle();
    chk(pv(o_p1_pad, 1'b1), 32'hFFFF_FFFF);
    chk(pv(o_p1_pad, 1'b0), 32'hF000_0001);
    rdc(P1 + `PPFS_GPIO_LEVEL, i_p1_level);
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial
  begin
    errors = 0;
    cmp_count = 0;
    i_reset_n = 1'b0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 32'h0000_0000;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    i_p0_level = 32'h7A00_0000;
    i_p1_level = 32'hA400_0000;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_mask();
    t_gpio();
    t_alt();
    t_port1();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors++;
    summarize();
  end
endmodule
